// ==== bench/ir_xcvr_model.sv ====
// Purpose: infrared transceiver seen at the receive pin
// Assumes: pol gives the idle level, light drives its inverse
// Notes: the transceiver always drives the line, it never floats
`timescale 1ns/100ps
`default_nettype none
module ir_xcvr_model (
	// clock and setting
	input wire logic aclk,
	input wire logic pol,
	// line
	output logic line
);
	logic lit = 1'b0;
	assign line = pol ^ lit;
	task automatic flash(input int n);
		lit <= 1'b1;
		repeat (n) @(posedge aclk);
		lit <= 1'b0;
		@(posedge aclk);
	endtask
endmodule // ir_xcvr_model
`default_nettype wire

// ==== bench/test_uart_irda_autobaud_irq.sv ====
// Purpose: self-checking bench of the infrared, auto-baud and flag block
// Assumes: one bus access at a time, answers queued in order
// Notes: source clock and bit ticks run random, or every cycle while fast is set; obc always runs random
`timescale 1ns/100ps
`default_nettype none
module test_uart_irda_autobaud_irq;
	import uart_irda_pkg::*;
	// ====
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rxd, rx_decoded, ir_codec_enable;
	logic [1:0] bresp, rresp, tirq, rirq;
	logic [5:0] plen;
	logic bsc = 1'b0, obc = 1'b0, btk = 1'b0, fast = 1'b0, lo_seen = 1'b0;
	logic obc_d, ptk, bupd;
	logic [4:0] ev [2] = '{5'h0, 5'h0};
	logic [15:0] rnd = 16'h3075;
	logic [33:0] exp_q [$];
	int err_total = 0, num_checks = 0, cycles = 0;
	always #2.5 aclk = ~aclk;
	uart_irda_autobaud_irq u_uart_irda_autobaud_irq (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .baud_source_clock(bsc), .oversampled_bit_clock(obc), .oversample_enable(fast),
		.bit_tick(btk), .serial_rx_input(rxd), .rx_decoded(rx_decoded), .ir_tx_pulse_tick(ptk),
		.ir_codec_enable(ir_codec_enable), .ir_tx_pulse_length(plen), .baud_update(bupd), .baud_measure(),
		.ch0_soft_reset(ev[0][4]), .ch0_tx_moved(ev[0][0]), .ch0_txbuf_write(ev[0][1]),
		.ch0_rx_char_done(ev[0][2]), .ch0_rxbuf_read(ev[0][3]), .ch0_rx_status_clear(),
		.ch0_tx_irq(tirq[0]), .ch0_rx_irq(rirq[0]), .ch1_soft_reset(ev[1][4]), .ch1_tx_moved(ev[1][0]),
		.ch1_txbuf_write(ev[1][1]), .ch1_rx_char_done(ev[1][2]), .ch1_rxbuf_read(ev[1][3]),
		.ch1_rx_status_clear(), .ch1_tx_irq(tirq[1]), .ch1_rx_irq(rirq[1]));
	ir_xcvr_model u_ir_xcvr_model (.aclk(aclk), .pol(1'b1), .line(rxd));
	// ====
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) bready <= 1'b0;
		end while (awvalid || wvalid || bready);
		// let an edge pass so the next request never re-raises a strobe in the same step
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		exp_q.push_back({r, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) rready <= 1'b0;
		end while (arvalid || rready);
		@(posedge aclk);
	endtask
	task automatic pulse(input int c, input int b);
		ev[c][b] <= 1'b1;
		@(posedge aclk);
		ev[c][b] <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic light(input int n, input logic e);
		lo_seen <= 1'b0;
		u_ir_xcvr_model.flash(n);
		repeat (10) @(posedge aclk);
		chk("light", 34'(lo_seen), 34'(e));
	endtask
	// ticks, timeout and answer monitor
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		rnd <= lfsr(rnd);
		bsc <= fast | rnd[0];
		btk <= fast | rnd[5];
		obc <= rnd[9];
		obc_d <= obc;
		if (!rx_decoded) lo_seen <= 1'b1;
		if (rvalid && rready) chk("read", {rresp, rdata}, exp_q.pop_front());
		if (bvalid && bready) chk("write", {bresp, 32'h0}, exp_q.pop_front());
		if (cycles == 20000) begin
			err_total++;
			final_report();
		end
	end
	// ====
	// scenarios
	initial begin
		logic [7:0] rst_v [7];
		logic [7:0] ie_a [2];
		logic [7:0] if_a [2];
		logic [7:0] rw;
		rst_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h02};
		ie_a = '{OFS_SH_IE, OFS_CH1_IE};
		if_a = '{OFS_SH_IFG, OFS_CH1_IFG};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 7; i++)
			rd(8'(4 * i), rst_v[i], RESP_OKAY);
		rd(8'h20, 8'h00, RESP_SLVERR);
		wr(8'h20, 8'hff, RESP_SLVERR);
		wr(OFS_AB_CTRL, 8'hff, RESP_OKAY);
		rd(OFS_AB_CTRL, 8'h3d, RESP_OKAY);
		wr(OFS_AB_CTRL, 8'h00, RESP_OKAY);
		for (int c = 0; c < 2; c++) begin
			rw = rnd[7:0];
			wr(ie_a[c], rw, RESP_OKAY);
			rd(ie_a[c], rw & (c ? 8'hf3 : 8'h03), RESP_OKAY);
			wr(ie_a[c], 8'h03, RESP_OKAY);
			pulse(c, 2);
			chk("irq", 34'({tirq[c], rirq[c]}), 34'h3);
			pulse(c, 3);
			rd(if_a[c], 8'h02, RESP_OKAY);
			pulse(c, 1);
			chk("irq", 34'({tirq[c], rirq[c]}), 34'h0);
			pulse(c, 0);
			pulse(c, 2);
			rd(if_a[c], 8'h03, RESP_OKAY);
			pulse(c, 4);
			rd(if_a[c], 8'h02, RESP_OKAY);
			rd(ie_a[c], 8'h00, RESP_OKAY);
		end
		fast <= 1'b1;
		wr(OFS_IR_TX_CTRL, 8'h07, RESP_OKAY);
		chk("codec", 34'({ir_codec_enable, plen}), 34'h41);
		repeat (4) begin
			chk("pulse clock", 34'(ptk), 34'(obc_d));
			@(posedge aclk);
		end
		wr(OFS_IR_RX_CTRL, 8'h02, RESP_OKAY);
		light(3, 1'b1);
		wr(OFS_IR_RX_CTRL, 8'h0b, RESP_OKAY);
		light(4, 1'b0);
		light(12, 1'b1);
		wr(OFS_IR_RX_CTRL, 8'h00, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk("steady light", 34'(rx_decoded), 34'h0);
		wr(OFS_IR_TX_CTRL, 8'h00, RESP_OKAY);
		wr(OFS_AB_CTRL, 8'h10, RESP_OKAY);
		u_ir_xcvr_model.flash(30);
		rd(OFS_AB_CTRL, 8'h10, RESP_OKAY);
		wr(OFS_AB_CTRL, 8'h11, RESP_OKAY);
		u_ir_xcvr_model.flash(30);
		rd(OFS_AB_CTRL, 8'h15, RESP_OKAY);
		// short break, four quiet bit times, then five falls two bit times apart
		u_ir_xcvr_model.flash(8);
		repeat (3) @(posedge aclk);
		repeat (5) u_ir_xcvr_model.flash(1);
		repeat (2) @(posedge aclk);
		chk("update", 34'(bupd), 34'h1);
		rd(OFS_AB_MEAS, 8'h08, RESP_OKAY);
		final_report();
	end
endmodule // test_uart_irda_autobaud_irq
bind uart_irda_autobaud_irq uart_irda_autobaud_irq_props u_uart_irda_autobaud_irq_props (.*);
`default_nettype wire

// ==== bench/uart_irda_autobaud_irq_props.sv ====
// Purpose: port checks of the bus, tick and flag logic
// Assumes: one clock, synchronous active low reset
// Notes: enables are internal, so irqs are judged at soft reset
`timescale 1ns/100ps
`default_nettype none
module uart_irda_autobaud_irq_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// ticks
	input wire logic baud_source_clock,
	input wire logic oversample_enable,
	input wire logic ir_tx_pulse_tick,
	// channel events
	input wire logic ch0_soft_reset,
	input wire logic ch1_soft_reset,
	input wire logic ch0_rxbuf_read,
	input wire logic ch1_rxbuf_read,
	input wire logic ch0_rx_status_clear,
	input wire logic ch1_rx_status_clear,
	input wire logic ch0_tx_irq,
	input wire logic ch0_rx_irq,
	input wire logic ch1_tx_irq,
	input wire logic ch1_rx_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ====
	// checks
	chk_sr0_quiet: assert property (ch0_soft_reset |=> !ch0_tx_irq && !ch0_rx_irq)
		else $error("ch0 irq after soft reset");
	chk_sr1_quiet: assert property (ch1_soft_reset |=> !ch1_tx_irq && !ch1_rx_irq)
		else $error("ch1 irq after soft reset");
	chk_clr0_delay: assert property (1'b1 |=> ch0_rx_status_clear == $past(ch0_rxbuf_read))
		else $error("ch0 status clear late");
	chk_clr1_delay: assert property (1'b1 |=> ch1_rx_status_clear == $past(ch1_rxbuf_read))
		else $error("ch1 status clear late");
	chk_txclk_src: assert property (!oversample_enable |=> ir_tx_pulse_tick == $past(baud_source_clock))
		else $error("pulse clock not source clock");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule // uart_irda_autobaud_irq_props
`default_nettype wire

// ==== core/autobaud_timer.sv ====
// Purpose: break and synch field measurement for automatic baud detection
// Assumes: bit_tick marks bit times, baud_tick marks source clock periods
// Notes: synch length is counted over eight bit times, start edge to fifth fall
`timescale 1ns/100ps
`default_nettype none
module autobaud_timer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic enable,
	input wire logic [1:0] delim_length,
	input wire logic bit_tick,
	input wire logic baud_tick,
	input wire logic rx,
	// results
	output logic break_timeout,
	output logic synch_timeout,
	output logic done,
	output logic [uart_irda_pkg::MEAS_W-1:0] measure
);
	import uart_irda_pkg::*;
	typedef enum logic [2:0] {AB_IDLE, AB_BREAK, AB_WAIT_HIGH, AB_DELIM, AB_SYNCH} ab_state_e;
	ab_state_e state;
	ab_state_e next_state;
	logic [MEAS_W-1:0] count;
	logic [MEAS_W-1:0] next_count;
	logic [2:0] edges;
	logic [2:0] next_edges;
	logic rx_d;
	logic fall;
	logic next_break_timeout;
	logic next_synch_timeout;
	logic next_done;
	logic [MEAS_W-1:0] next_measure;

	// ===================================
	// measurement sequence
	always_comb begin
		fall = rx_d & ~rx;
		next_state = state;
		next_count = count;
		next_edges = edges;
		next_break_timeout = 1'b0;
		next_synch_timeout = 1'b0;
		next_done = 1'b0;
		next_measure = measure;
		case (state)
			AB_IDLE: begin
				next_count = '0;
				if (enable && fall) begin
					next_state = AB_BREAK;
				end
			end
			AB_BREAK: begin
				if (rx) begin
					next_state = AB_DELIM;
					next_count = '0;
				end else if (bit_tick) begin
					next_count = count + 16'h0001;
					if (count >= {11'h000, BREAK_MAX_BITS}) begin
						next_break_timeout = 1'b1;
						next_state = AB_WAIT_HIGH;
					end
				end
			end
			AB_WAIT_HIGH: begin
				if (rx) begin
					next_state = AB_IDLE;
				end
			end
			AB_DELIM: begin
				if (fall) begin
					// delimiter too short means this was no break
					next_state = (count > {14'h0000, delim_length}) ? AB_SYNCH : AB_IDLE;
					next_count = '0;
					next_edges = 3'h1;
				end else if (bit_tick && count != 16'hffff) begin
					next_count = count + 16'h0001;
				end
			end
			AB_SYNCH: begin
				if (fall && edges == SYNCH_FALL_EDGES - 3'h1) begin
					next_done = 1'b1;
					// the closing tick belongs to the field, so 8 bit times of 1 tick read 8
					next_measure = count + {15'h0000, baud_tick};
					next_state = AB_IDLE;
				end else begin
					if (fall) begin
						next_edges = edges + 3'h1;
					end
					if (baud_tick) begin
						if (count == 16'hffff) begin
							next_synch_timeout = 1'b1;
							next_state = AB_WAIT_HIGH;
						end else begin
							next_count = count + 16'h0001;
						end
					end
				end
			end
			default: next_state = AB_IDLE;
		endcase
		if (!enable) begin
			next_state = AB_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= AB_IDLE;
			count <= '0;
			edges <= 3'h0;
			rx_d <= 1'b1;
			break_timeout <= 1'b0;
			synch_timeout <= 1'b0;
			done <= 1'b0;
			measure <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
			edges <= next_edges;
			rx_d <= rx;
			break_timeout <= next_break_timeout;
			synch_timeout <= next_synch_timeout;
			done <= next_done;
			measure <= next_measure;
		end
	end
endmodule // autobaud_timer
`default_nettype wire

// ==== core/ir_rx_filter.sv ====
// Purpose: infrared receive polarity and pulse length filter
// Assumes: half_tick pulses once for every edge of the baud source clock
// Notes: an accepted pulse is reported late by its minimum length
`timescale 1ns/100ps
`default_nettype none
module ir_rx_filter (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// settings
	input wire logic filter_enable,
	input wire logic polarity,
	input wire logic [5:0] filter_length,
	input wire logic half_tick,
	// line
	input wire logic rx_in,
	output logic light_out
);
	import uart_irda_pkg::*;
	logic [6:0] count;
	logic [6:0] next_count;
	logic next_light_out;
	logic light;

	// ===================================
	// filter
	always_comb begin
		light = polarity ? ~rx_in : rx_in;
		next_count = count;
		next_light_out = light_out;
		if (!filter_enable) begin
			next_count = 7'h00;
			next_light_out = light;
		end else if (!light) begin
			next_count = 7'h00;
			next_light_out = 1'b0;
		end else if (half_tick) begin
			// half periods of the source clock: (length + 4) / (2 f)
			if (count >= {1'b0, filter_length} + FILTER_BASE) begin
				next_light_out = 1'b1;
			end else begin
				next_count = count + 7'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 7'h00;
			light_out <= 1'b0;
		end else begin
			count <= next_count;
			light_out <= next_light_out;
		end
	end
endmodule // ir_rx_filter
`default_nettype wire

// ==== core/uart_irda_autobaud_irq.sv ====
// Purpose: infrared codec settings, auto-baud detection and channel interrupt flags
// Assumes: AXI4-Lite slave, 8-bit registers in byte lane 0 except the 16-bit measure, ticks are enables
// Notes: the buffers and shift registers live outside and report by pulses
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Transmit pulse clock: source clock at 0, oversampled clock at 1 if oversampling.
// - Control bit 0 switches the infrared encoder and decoder on.
// - Receive filter minimum pulse is (length plus 4) source half periods.
// - Receive polarity 0 takes high pulses as light, 1 takes low pulses.
// - Receive control bit 0 enables the pulse filter, otherwise bypassed.
// - Delimiter field selects one to four bit times of delimiter.
// - Synch timeout flag sets when synch length overflows the counter.
// - Break timeout flag sets when break exceeds 22 bit times.
// - Auto-baud enable measures break and synch and updates baud rate.
// - Auto-baud bits 7-6 and 1 are reserved and read zero.
// - Channel 0 enables: bit 1 transmit, bit 0 receive, reset disabled.
// - Channel 0 transmit flag sets when its buffer empties, resets to 1.
// - Channel 0 receive flag sets on a complete character, resets to 0.
// - Shared enable and flag bits 7-2 are left alone by this block.
// - Channel 1 enables: bit 1 transmit, bit 0 receive, reset disabled.
// - Channel 1 transmit flag resets 1, receive flag resets 0, same events.
// - Channel 1 bits 7-4 are spare read/write, bits 3-2 not ours.
// - Reading the receive buffer clears receive flag, errors and address/idle.
// - Writing the transmit buffer clears transmit flag until data moves on.
// - Soft reset clears enables and receive flag and sets transmit flag.
module uart_irda_autobaud_irq (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// rate enables
	input wire logic baud_source_clock,
	input wire logic oversampled_bit_clock,
	input wire logic oversample_enable,
	input wire logic bit_tick,
	// line
	input wire logic serial_rx_input,
	output logic rx_decoded,
	output logic ir_tx_pulse_tick,
	output logic ir_codec_enable,
	output logic [5:0] ir_tx_pulse_length,
	// baud update
	output logic baud_update,
	output logic [uart_irda_pkg::MEAS_W-1:0] baud_measure,
	// channel 0 events
	input wire logic ch0_soft_reset,
	input wire logic ch0_tx_moved,
	input wire logic ch0_txbuf_write,
	input wire logic ch0_rx_char_done,
	input wire logic ch0_rxbuf_read,
	output logic ch0_rx_status_clear,
	output logic ch0_tx_irq,
	output logic ch0_rx_irq,
	// channel 1 events
	input wire logic ch1_soft_reset,
	input wire logic ch1_tx_moved,
	input wire logic ch1_txbuf_write,
	input wire logic ch1_rx_char_done,
	input wire logic ch1_rxbuf_read,
	output logic ch1_rx_status_clear,
	output logic ch1_tx_irq,
	output logic ch1_rx_irq
);
	import uart_irda_pkg::*;

	// ===================================
	// state
	logic [7:0] ir_tx_ctrl;
	logic [7:0] ir_rx_ctrl;
	logic [7:0] ab_ctrl;
	logic [1:0] ch0_ie;
	logic [1:0] ch0_ifg;
	logic [7:0] ch1_ie;
	logic [7:0] ch1_ifg;
	logic [7:0] next_ir_tx_ctrl;
	logic [7:0] next_ir_rx_ctrl;
	logic [7:0] next_ab_ctrl;
	logic [1:0] next_ch0_ie;
	logic [1:0] next_ch0_ifg;
	logic [7:0] next_ch1_ie;
	logic [7:0] next_ch1_ifg;
	logic [7:0] aw_addr;
	logic aw_full;
	logic [7:0] w_data;
	logic w_en;
	logic w_full;
	logic [7:0] next_aw_addr;
	logic next_aw_full;
	logic [7:0] next_w_data;
	logic next_w_en;
	logic next_w_full;
	logic next_awready;
	logic next_wready;
	logic [1:0] next_bresp;
	logic next_bvalid;
	logic next_arready;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_rvalid;
	logic do_write;
	logic light;
	logic ab_break_to;
	logic ab_synch_to;
	logic ab_done;
	logic [MEAS_W-1:0] ab_measure;
	logic next_rx_decoded;
	logic next_tx_tick;
	logic [MEAS_W-1:0] next_baud_measure;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFS_AB_MEAS);
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] tx, input logic [7:0] rx,
			input logic [7:0] ab, input logic [1:0] ie0, input logic [1:0] if0, input logic [7:0] ie1,
			input logic [7:0] if1);
		case (a)
			OFS_IR_TX_CTRL: read_reg = tx;
			OFS_IR_RX_CTRL: read_reg = rx;
			OFS_AB_CTRL: read_reg = ab;
			OFS_SH_IE: read_reg = {6'h00, ie0};
			OFS_SH_IFG: read_reg = {6'h00, if0};
			OFS_CH1_IE: read_reg = ie1;
			OFS_CH1_IFG: read_reg = if1;
			default: read_reg = 8'h00;
		endcase
	endfunction

	// flag update: soft reset wins first, then hardware set wins over buffer clear and write
	function automatic logic flag_next(input logic cur, input logic rst_val, input logic soft_rst,
			input logic set, input logic clr, input logic wr, input logic wbit);
		if (soft_rst) begin
			flag_next = rst_val;
		end else if (set) begin
			flag_next = 1'b1;
		end else if (clr) begin
			flag_next = 1'b0;
		end else if (wr) begin
			flag_next = wbit;
		end else begin
			flag_next = cur;
		end
	endfunction

	// ===================================
	// receive path and auto-baud
	ir_rx_filter u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.filter_enable(ir_rx_ctrl[BIT_IR_RXFE]),
		.polarity(ir_rx_ctrl[BIT_IR_RXPL]),
		.filter_length(ir_rx_ctrl[LSB_FIELD6+:6]),
		.half_tick(baud_source_clock),
		.rx_in(serial_rx_input),
		.light_out(light)
	);

	autobaud_timer u_autobaud (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(ab_ctrl[BIT_AB_EN]),
		.delim_length(ab_ctrl[LSB_AB_DELIM+:2]),
		.bit_tick(bit_tick),
		.baud_tick(baud_source_clock),
		.rx(rx_decoded),
		.break_timeout(ab_break_to),
		.synch_timeout(ab_synch_to),
		.done(ab_done),
		.measure(ab_measure)
	);

	// ===================================
	// axi4-lite slave
	always_comb begin
		next_aw_addr = aw_addr;
		next_aw_full = aw_full;
		next_w_data = w_data;
		next_w_en = w_en;
		next_w_full = w_full;
		next_bresp = s_axi_bresp;
		next_bvalid = s_axi_bvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_rvalid = s_axi_rvalid;
		next_arready = s_axi_arready;
		// address and data are taken in either order, then joined
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_addr = s_axi_awaddr;
			next_aw_full = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data = s_axi_wdata[7:0];
			next_w_en = s_axi_wstrb[0];
			next_w_full = 1'b1;
		end
		do_write = aw_full && w_full && !s_axi_bvalid;
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr == OFS_AB_MEAS) begin
				next_rdata = {{(32 - MEAS_W){1'b0}}, baud_measure};
			end else begin
				next_rdata = {24'h000000, read_reg(s_axi_araddr, ir_tx_ctrl, ir_rx_ctrl, ab_ctrl, ch0_ie, ch0_ifg,
					ch1_ie, ch1_ifg)};
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= 8'h00;
			aw_full <= 1'b0;
			w_data <= 8'h00;
			w_en <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bresp <= RESP_OKAY;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
		end else begin
			aw_addr <= next_aw_addr;
			aw_full <= next_aw_full;
			w_data <= next_w_data;
			w_en <= next_w_en;
			w_full <= next_w_full;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bresp <= next_bresp;
			s_axi_bvalid <= next_bvalid;
			s_axi_arready <= next_arready;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_rvalid <= next_rvalid;
		end
	end

	// ===================================
	// registers, flags and line outputs
	always_comb begin
		logic wr_ok;
		wr_ok = do_write && w_en;
		next_ir_tx_ctrl = ir_tx_ctrl;
		next_ir_rx_ctrl = ir_rx_ctrl;
		next_ab_ctrl = ab_ctrl;
		next_ch0_ie = ch0_ie;
		next_ch1_ie = ch1_ie;
		if (wr_ok && aw_addr == OFS_IR_TX_CTRL) begin
			next_ir_tx_ctrl = w_data;
		end
		if (wr_ok && aw_addr == OFS_IR_RX_CTRL) begin
			next_ir_rx_ctrl = w_data;
		end
		if (wr_ok && aw_addr == OFS_AB_CTRL) begin
			next_ab_ctrl = w_data & 8'h3d;
		end
		// hardware timeouts win over a software write in the same cycle
		if (ab_break_to) begin
			next_ab_ctrl[BIT_AB_BTOE] = 1'b1;
		end
		if (ab_synch_to) begin
			next_ab_ctrl[BIT_AB_STOE] = 1'b1;
		end
		if (wr_ok && aw_addr == OFS_SH_IE) begin
			next_ch0_ie = w_data[1:0];
		end
		if (ch0_soft_reset) begin
			next_ch0_ie = {RST_IE, RST_IE};
		end
		if (wr_ok && aw_addr == OFS_CH1_IE) begin
			next_ch1_ie = {w_data[7:LSB_CH1_SPARE], 2'h0, w_data[1:0]};
		end
		if (ch1_soft_reset) begin
			next_ch1_ie[1:0] = {RST_IE, RST_IE};
		end
		next_ch0_ifg[BIT_TX] = flag_next(ch0_ifg[BIT_TX], RST_TX_FLAG, ch0_soft_reset, ch0_tx_moved,
			ch0_txbuf_write, wr_ok && aw_addr == OFS_SH_IFG, w_data[BIT_TX]);
		next_ch0_ifg[BIT_RX] = flag_next(ch0_ifg[BIT_RX], RST_RX_FLAG, ch0_soft_reset, ch0_rx_char_done,
			ch0_rxbuf_read, wr_ok && aw_addr == OFS_SH_IFG, w_data[BIT_RX]);
		next_ch1_ifg = ch1_ifg;
		if (wr_ok && aw_addr == OFS_CH1_IFG) begin
			next_ch1_ifg[7:LSB_CH1_SPARE] = w_data[7:LSB_CH1_SPARE];
		end
		next_ch1_ifg[BIT_TX] = flag_next(ch1_ifg[BIT_TX], RST_TX_FLAG, ch1_soft_reset, ch1_tx_moved,
			ch1_txbuf_write, wr_ok && aw_addr == OFS_CH1_IFG, w_data[BIT_TX]);
		next_ch1_ifg[BIT_RX] = flag_next(ch1_ifg[BIT_RX], RST_RX_FLAG, ch1_soft_reset, ch1_rx_char_done,
			ch1_rxbuf_read, wr_ok && aw_addr == OFS_CH1_IFG, w_data[BIT_RX]);
		// a light pulse decodes to a zero bit; codec off passes the line through
		next_rx_decoded = ir_tx_ctrl[BIT_IR_EN] ? ~light : serial_rx_input;
		next_tx_tick = (ir_tx_ctrl[BIT_IR_TXCLK] && oversample_enable) ? oversampled_bit_clock
			: baud_source_clock;
		next_baud_measure = ab_done ? ab_measure : baud_measure;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_tx_ctrl <= RST_CTRL;
			ir_rx_ctrl <= RST_CTRL;
			ab_ctrl <= RST_CTRL;
			ch0_ie <= {RST_IE, RST_IE};
			ch0_ifg <= {RST_TX_FLAG, RST_RX_FLAG};
			ch1_ie <= RST_CTRL;
			ch1_ifg <= {6'h00, RST_TX_FLAG, RST_RX_FLAG};
			rx_decoded <= 1'b1;
			ir_tx_pulse_tick <= 1'b0;
			ir_codec_enable <= 1'b0;
			ir_tx_pulse_length <= 6'h00;
			baud_update <= 1'b0;
			baud_measure <= '0;
			ch0_rx_status_clear <= 1'b0;
			ch1_rx_status_clear <= 1'b0;
			ch0_tx_irq <= 1'b0;
			ch0_rx_irq <= 1'b0;
			ch1_tx_irq <= 1'b0;
			ch1_rx_irq <= 1'b0;
		end else begin
			ir_tx_ctrl <= next_ir_tx_ctrl;
			ir_rx_ctrl <= next_ir_rx_ctrl;
			ab_ctrl <= next_ab_ctrl;
			ch0_ie <= next_ch0_ie;
			ch0_ifg <= next_ch0_ifg;
			ch1_ie <= next_ch1_ie;
			ch1_ifg <= next_ch1_ifg;
			rx_decoded <= next_rx_decoded;
			ir_tx_pulse_tick <= next_tx_tick;
			ir_codec_enable <= next_ir_tx_ctrl[BIT_IR_EN];
			ir_tx_pulse_length <= next_ir_tx_ctrl[LSB_FIELD6+:6];
			baud_update <= ab_done;
			baud_measure <= next_baud_measure;
			ch0_rx_status_clear <= ch0_rxbuf_read;
			ch1_rx_status_clear <= ch1_rxbuf_read;
			// requests follow the next flag and enable values, so no cycle of lag
			ch0_tx_irq <= next_ch0_ifg[BIT_TX] & next_ch0_ie[BIT_TX];
			ch0_rx_irq <= next_ch0_ifg[BIT_RX] & next_ch0_ie[BIT_RX];
			ch1_tx_irq <= next_ch1_ifg[BIT_TX] & next_ch1_ie[BIT_TX];
			ch1_rx_irq <= next_ch1_ifg[BIT_RX] & next_ch1_ie[BIT_RX];
		end
	end
endmodule // uart_irda_autobaud_irq
`default_nettype wire

// ==== core/uart_irda_pkg.sv ====
// Purpose: shared constants for the infrared, auto-baud and interrupt flag block
// Assumes: AXI4-Lite register bus, 32-bit data, one register per word
// Notes: registers are 8 bits wide in the low lane except the 16-bit measure, upper bits read as zero
package uart_irda_pkg;
	// ===================================
	// register byte addresses
	localparam logic [7:0] OFS_IR_TX_CTRL = 8'h00;
	localparam logic [7:0] OFS_IR_RX_CTRL = 8'h04;
	localparam logic [7:0] OFS_AB_CTRL = 8'h08;
	localparam logic [7:0] OFS_SH_IE = 8'h0c;
	localparam logic [7:0] OFS_SH_IFG = 8'h10;
	localparam logic [7:0] OFS_CH1_IE = 8'h14;
	localparam logic [7:0] OFS_CH1_IFG = 8'h18;
	localparam logic [7:0] OFS_AB_MEAS = 8'h1c;
	// ===================================
	// field positions
	localparam int BIT_IR_EN = 0;
	localparam int BIT_IR_TXCLK = 1;
	localparam int BIT_IR_RXFE = 0;
	localparam int BIT_IR_RXPL = 1;
	localparam int LSB_FIELD6 = 2;
	localparam int BIT_AB_EN = 0;
	localparam int BIT_AB_BTOE = 2;
	localparam int BIT_AB_STOE = 3;
	localparam int LSB_AB_DELIM = 4;
	localparam int BIT_RX = 0;
	localparam int BIT_TX = 1;
	localparam int LSB_CH1_SPARE = 4;
	// ===================================
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic RST_TX_FLAG = 1'b1;
	localparam logic RST_RX_FLAG = 1'b0;
	localparam logic RST_IE = 1'b0;
	// ===================================
	// timing counts
	localparam logic [4:0] BREAK_MAX_BITS = 5'h16;
	localparam logic [6:0] FILTER_BASE = 7'h04;
	localparam logic [2:0] SYNCH_FALL_EDGES = 3'h5;
	localparam int MEAS_W = 16;
	// ===================================
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
